// ### pbseq_cpu_model.sv
`timescale 1ns/1ps
// processor model: boots slowly, answers the alert at once or never
module pbseq_cpu_model (
	// clock and power state
	input  wire logic sys_clk,
	input  wire logic en,
	input  wire logic powerdown_alert_n,
	// behaviour selects from the bench
	input  wire logic boot_ok,
	input  wire logic ack_ok,
	input  wire logic kill,
	// request pin
	output logic      shutdown_req_n
);
	int cnt = 0;

	initial shutdown_req_n = 1'b0;
	always @(posedge sys_clk) begin
		#1;
		if (en !== 1'b1) begin
			// unpowered processor holds its pin low
			shutdown_req_n <= 1'b0;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
			if (boot_ok && cnt == 200) begin
				shutdown_req_n <= 1'b1;
			end
			if (kill || (ack_ok && powerdown_alert_n === 1'b0)) begin
				shutdown_req_n <= 1'b0;
			end
		end
	end
endmodule : pbseq_cpu_model

// ### pbseq_pkg.sv
package pbseq_pkg;
	// timebase: one tick per millisecond
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	// intervals in milliseconds
	localparam int unsigned ON_DEBOUNCE_MS  = 128;
	localparam int unsigned STARTUP_BLANK_MS = 512;
	localparam int unsigned RELEASE_DB_MS   = 32;
	localparam int unsigned OFF_DEBOUNCE_MS = 32;
	localparam int unsigned FAILSAFE_MS     = 128;
	localparam int unsigned LOCKOUT_MS      = 256;
	localparam int unsigned MS_W            = 16;
	// reset values
	localparam logic        SYNC_RESET_VAL  = 1'b1;
	localparam logic        ALERT_IDLE_N    = 1'b1;

	typedef enum logic [2:0] {
		PBSEQ_IDLE     = 3'b000,
		PBSEQ_ON_DB    = 3'b001,
		PBSEQ_BLANK    = 3'b011,
		PBSEQ_REL_DB   = 3'b010,
		PBSEQ_RUN      = 3'b110,
		PBSEQ_OFF_DB   = 3'b111,
		PBSEQ_FAILSAFE = 3'b101,
		PBSEQ_LOCKOUT  = 3'b100
	} pbseq_state_e;
endpackage : pbseq_pkg

// ### pbseq_sync.sv
`timescale 1ns/1ps
module pbseq_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// pin in, synchronised out
	input  wire logic pin_async,
	output logic      pin_sync
);
	logic meta_q;
	logic sync_q;
	logic meta_d;
	logic sync_d;

	always_comb begin
		meta_d = pin_async;
		sync_d = meta_q;
	end

	// inputs idle high so reset value is the inactive level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= pbseq_pkg::SYNC_RESET_VAL;
			sync_q <= pbseq_pkg::SYNC_RESET_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pin_sync = sync_q;
endmodule : pbseq_sync

// ### pbseq_testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int TK = 4;
	logic                       sys_clk = 1'b0;
	logic                       rst_n = 1'b0;
	logic                       pushbutton_n = 1'b1;
	logic                       boot_ok = 1'b0;
	logic                       ack_ok = 1'b0;
	logic                       kill = 1'b0;
	logic [pbseq_pkg::MS_W-1:0] off_ext = 16'h0000;
	logic [pbseq_pkg::MS_W-1:0] fs_ext = 16'h0000;
	logic                       shutdown_req_n;
	logic                       pe;
	logic                       pe_lo;
	logic                       al;
	logic                       al_lo;
	int                         fail_count = 0;
	int                         compares = 0;
	int                         n;

	pbseq_top #(.EN_ACTIVE_HIGH(1'b1), .TICK_CYCLES(TK)) pbseq_top_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .pushbutton_n(pushbutton_n),
		.shutdown_req_n(shutdown_req_n), .off_debounce_extend(off_ext),
		.failsafe_delay_extend(fs_ext), .power_enable(pe),
		.powerdown_alert_n(al));
	// low-true variant shares every input
	pbseq_top #(.EN_ACTIVE_HIGH(1'b0), .TICK_CYCLES(TK)) pbseq_top_i_lo (
		.sys_clk(sys_clk), .rst_n(rst_n), .pushbutton_n(pushbutton_n),
		.shutdown_req_n(shutdown_req_n), .off_debounce_extend(off_ext),
		.failsafe_delay_extend(fs_ext), .power_enable(pe_lo),
		.powerdown_alert_n(al_lo));
	pbseq_cpu_model pbseq_cpu_model_i (
		.sys_clk(sys_clk), .en(pe), .powerdown_alert_n(al),
		.boot_ok(boot_ok), .ack_ok(ack_ok), .kill(kill),
		.shutdown_req_n(shutdown_req_n));

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	task stop_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task chk(input string nm, input int exp, input int got, input int tol);
		compares++;
		if (got < exp || got > exp + tol) begin
			fail_count++;
			$display("BAD %s exp %0d got %0d", nm, exp, got);
		end
	endtask : chk

	task chkb(input string nm, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %b got %b", nm, exp, got);
		end
	endtask : chkb

	task btn(input logic v, input int ticks);
		pushbutton_n = v;
		repeat (ticks * TK) begin
			@(posedge sys_clk);
			#1;
		end
	endtask : btn

	// a = 1 waits on the alert, a = 0 on the enable
	task wt(input bit a, input logic v, input int max, output int k);
		k = 0;
		while ((a ? al : pe) !== v) begin
			@(posedge sys_clk);
			#1;
			k++;
			if (k > max) begin
				fail_count++;
				$display("BAD wait exp %0d got %0d", max, k);
				stop_test();
			end
		end
	endtask : wt

	task done(input string nm);
		chkb("variant", ~pe, pe_lo);
		chkb("variant_alert", al, al_lo);
		$display("test %s done", nm);
	endtask : done

	// press on, then a long press during blanking that must be ignored
	task power_on();
		boot_ok = 1'b1;
		pushbutton_n = 1'b0;
		wt(0, 1'b1, 140 * TK, n);
		btn(1'b1, 10);
		btn(1'b0, 100);
		btn(1'b1, 460);
		chkb("blank_press", 1'b1, al);
		chkb("run_on", 1'b1, pe);
	endtask : power_on

	task t_reset();
		repeat (5) @(posedge sys_clk);
		#1;
		chkb("reset_en", 1'b0, pe);
		chkb("reset_alert", 1'b1, al);
		repeat (5) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		done("reset");
	endtask : t_reset

	task t_abort();
		btn(1'b0, 100);
		btn(1'b1, 1);
		chkb("short_press", 1'b0, pe);
		pushbutton_n = 1'b0;
		wt(0, 1'b1, 140 * TK, n);
		chk("on_time", 128 * TK, n, 3 * TK);
		wt(0, 1'b0, 520 * TK, n);
		// tick phase puts the last tick 1..TK cycles past a whole count
		chk("abort_time", 511 * TK + 1, n, TK);
		chkb("abort_alert", 1'b1, al);
		btn(1'b1, 40);
		done("abort");
	endtask : t_abort

	task t_off_ack();
		ack_ok = 1'b1;
		off_ext = 16'h0005;
		power_on();
		btn(1'b0, 30);
		btn(1'b1, 1);
		pushbutton_n = 1'b0;
		wt(1, 1'b0, 40 * TK, n);
		chk("off_debounce", 37 * TK, n, 3 * TK);
		wt(0, 1'b0, 10, n);
		chk("ack_release", 1, n, 5);
		chkb("alert_back", 1'b1, al);
		// release by request enters lockout; wait it out plus release debounce
		btn(1'b1, 300);
		done("off_ack");
	endtask : t_off_ack

	task t_failsafe();
		ack_ok = 1'b0;
		fs_ext = 16'h0007;
		power_on();
		pushbutton_n = 1'b0;
		wt(1, 1'b0, 40 * TK, n);
		wt(0, 1'b0, 140 * TK, n);
		chk("failsafe", 134 * TK + 1, n, TK);
		chkb("fs_alert", 1'b1, al);
		btn(1'b1, 40);
		done("failsafe");
	endtask : t_failsafe

	task t_kill_lockout();
		power_on();
		kill = 1'b1;
		wt(0, 1'b0, 10, n);
		chk("kill_release", 1, n, 5);
		kill = 1'b0;
		btn(1'b1, 10);
		btn(1'b0, 190);
		chkb("lockout", 1'b0, pe);
		btn(1'b1, 150);
		pushbutton_n = 1'b0;
		wt(0, 1'b1, 140 * TK, n);
		chk("restart", 128 * TK, n, 3 * TK);
		done("kill_lockout");
	endtask : t_kill_lockout

	initial begin
		t_reset();
		t_abort();
		t_off_ack();
		t_failsafe();
		t_kill_lockout();
		stop_test();
	end
endmodule : testbench

// ### pbseq_tick.sv
`timescale 1ns/1ps
module pbseq_tick #(
	parameter int unsigned CYCLES = pbseq_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// tick out
	pbseq_tick_if.src tk
);
	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	initial begin
		if (CYCLES < 2) $error("tick period must be at least two cycles");
	end

	always_comb begin
		tick_d = (cnt_q == CW'(CYCLES - 1));
		cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tk.tick = tick_q;

	a_tick_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tick_q |=> !tick_q) else $error("tick lasted more than one cycle");
endmodule : pbseq_tick

// ### pbseq_tick_if.sv
`timescale 1ns/1ps
interface pbseq_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : pbseq_tick_if

// ### pbseq_top.sv
`timescale 1ns/1ps
// Summary of operation
// - enable asserts after pushbutton held low 128 ms; high restarts timing.
// - enable assertion starts a 512 ms start-up blanking timer.
// - shutdown request still low at blanking end aborts power-on.
// - shutdown request and pushbutton ignored during blanking.
// - after blanking, pushbutton release debounced for 32 ms.
// - turn-off press needs 32 ms plus extension of continuous low.
// - completed turn-off debounce drives the alert output low.
// - failsafe timer starts together with alert going low.
// - failsafe reaching 128 ms plus extension releases enable.
// - shutdown request low releases enable at once, cancels failsafe.
// - after power-off, pushbutton release debounced for 32 ms.
// - shutdown request low in normal operation releases enable.
// - after release by shutdown request (not the blanking-end abort), pushbutton ignored 256 ms.
// - after power-off return idle, wait for a new press.
// - enable polarity selectable: active high or active low.
// - at reset enable is deasserted.
module pbseq_top #(
	parameter bit          EN_ACTIVE_HIGH = 1'b1,
	parameter int unsigned TICK_CYCLES    = pbseq_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	// pushbutton and processor pins
	input  wire logic                      pushbutton_n,
	input  wire logic                      shutdown_req_n,
	// configuration, milliseconds
	input  wire logic [pbseq_pkg::MS_W-1:0] off_debounce_extend,
	input  wire logic [pbseq_pkg::MS_W-1:0] failsafe_delay_extend,
	// outputs
	output logic                           power_enable,
	output logic                           powerdown_alert_n
);
	localparam int unsigned W = pbseq_pkg::MS_W + 1;

	pbseq_tick_if tk_if ();
	logic pb_s;
	logic kill_s;

	pbseq_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tk      (tk_if.src)
	);

	pbseq_sync u_sync_pb (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin_async (pushbutton_n),
		.pin_sync  (pb_s)
	);

	pbseq_sync u_sync_kill (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin_async (shutdown_req_n),
		.pin_sync  (kill_s)
	);

	pbseq_pkg::pbseq_state_e state_q;
	pbseq_pkg::pbseq_state_e state_d;
	logic [W-1:0]            ms_q;
	logic [W-1:0]            ms_d;
	logic                    on_q;
	logic                    on_d;
	logic                    alert_n_q;
	logic                    alert_n_d;
	logic                    en_pin_q;
	logic [W-1:0]            off_lim;
	logic [W-1:0]            fs_lim;
	logic                    tick;

	assign tick    = tk_if.dst.tick;
	// extensions add to the fixed defaults; widened so no overflow
	assign off_lim = W'(pbseq_pkg::OFF_DEBOUNCE_MS) + W'(off_debounce_extend);
	assign fs_lim  = W'(pbseq_pkg::FAILSAFE_MS) + W'(failsafe_delay_extend);

	// ms_q counts completed ticks inside the current state
	always_comb begin
		state_d   = state_q;
		ms_d      = tick ? ms_q + 1'b1 : ms_q;
		on_d      = on_q;
		alert_n_d = alert_n_q;
		unique case (state_q)
			pbseq_pkg::PBSEQ_IDLE: begin
				ms_d = '0;
				if (!pb_s) begin
					state_d = pbseq_pkg::PBSEQ_ON_DB;
				end
			end
			pbseq_pkg::PBSEQ_ON_DB: begin
				if (pb_s) begin
					state_d = pbseq_pkg::PBSEQ_IDLE;
					ms_d    = '0;
				end else if (ms_d >= W'(pbseq_pkg::ON_DEBOUNCE_MS)) begin
					state_d = pbseq_pkg::PBSEQ_BLANK;
					on_d    = 1'b1;
					ms_d    = '0;
				end
			end
			pbseq_pkg::PBSEQ_BLANK: begin
				// both inputs ignored until the window closes
				if (ms_d >= W'(pbseq_pkg::STARTUP_BLANK_MS)) begin
					ms_d = '0;
					if (!kill_s) begin
						on_d    = 1'b0;
						state_d = pbseq_pkg::PBSEQ_REL_DB;
					end else begin
						state_d = pbseq_pkg::PBSEQ_REL_DB;
					end
				end
			end
			pbseq_pkg::PBSEQ_REL_DB: begin
				if (on_q && !kill_s) begin
					on_d    = 1'b0;
					state_d = pbseq_pkg::PBSEQ_LOCKOUT;
					ms_d    = '0;
				end else if (!pb_s) begin
					ms_d = '0;
				end else if (ms_d >= W'(pbseq_pkg::RELEASE_DB_MS)) begin
					ms_d    = '0;
					state_d = on_q ? pbseq_pkg::PBSEQ_RUN
					               : pbseq_pkg::PBSEQ_IDLE;
				end
			end
			pbseq_pkg::PBSEQ_RUN: begin
				ms_d = '0;
				if (!kill_s) begin
					on_d    = 1'b0;
					state_d = pbseq_pkg::PBSEQ_LOCKOUT;
				end else if (!pb_s) begin
					state_d = pbseq_pkg::PBSEQ_OFF_DB;
				end
			end
			pbseq_pkg::PBSEQ_OFF_DB: begin
				if (!kill_s) begin
					on_d    = 1'b0;
					state_d = pbseq_pkg::PBSEQ_LOCKOUT;
					ms_d    = '0;
				end else if (pb_s) begin
					state_d = pbseq_pkg::PBSEQ_RUN;
					ms_d    = '0;
				end else if (ms_d >= off_lim) begin
					alert_n_d = 1'b0;
					state_d   = pbseq_pkg::PBSEQ_FAILSAFE;
					ms_d      = '0;
				end
			end
			pbseq_pkg::PBSEQ_FAILSAFE: begin
				if (!kill_s) begin
					on_d      = 1'b0;
					alert_n_d = 1'b1;
					state_d   = pbseq_pkg::PBSEQ_LOCKOUT;
					ms_d      = '0;
				end else if (ms_d >= fs_lim) begin
					on_d      = 1'b0;
					alert_n_d = 1'b1;
					state_d   = pbseq_pkg::PBSEQ_REL_DB;
					ms_d      = '0;
				end
			end
			pbseq_pkg::PBSEQ_LOCKOUT: begin
				// converter output decays before a restart is allowed
				if (ms_d >= W'(pbseq_pkg::LOCKOUT_MS)) begin
					state_d = pbseq_pkg::PBSEQ_REL_DB;
					ms_d    = '0;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= pbseq_pkg::PBSEQ_IDLE;
			ms_q      <= '0;
			on_q      <= 1'b0;
			alert_n_q <= pbseq_pkg::ALERT_IDLE_N;
			en_pin_q  <= ~EN_ACTIVE_HIGH;
		end else begin
			state_q   <= state_d;
			ms_q      <= ms_d;
			on_q      <= on_d;
			alert_n_q <= alert_n_d;
			en_pin_q  <= on_d ~^ EN_ACTIVE_HIGH;
		end
	end

	assign power_enable      = en_pin_q;
	assign powerdown_alert_n = alert_n_q;

	a_en_matches_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		power_enable == (on_q ~^ EN_ACTIVE_HIGH))
		else $error("enable pin polarity wrong");
	a_on_needs_db: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(on_q) |-> $past(state_q) == pbseq_pkg::PBSEQ_ON_DB && !$past(pb_s))
		else $error("enable rose without on debounce");
	a_blank_holds_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pbseq_pkg::PBSEQ_BLANK |-> on_q)
		else $error("enable dropped during blanking");
	a_abort_at_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pbseq_pkg::PBSEQ_BLANK && state_d != state_q && !kill_s
		|=> !on_q) else $error("power-on not aborted");
	a_kill_releases: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pbseq_pkg::PBSEQ_RUN || state_q == pbseq_pkg::PBSEQ_FAILSAFE)
		&& !kill_s |=> !on_q && state_q == pbseq_pkg::PBSEQ_LOCKOUT)
		else $error("shutdown request did not release");
	a_alert_with_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!alert_n_q |-> on_q && state_q == pbseq_pkg::PBSEQ_FAILSAFE)
		else $error("alert low outside failsafe");
	a_alert_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(alert_n_q) |-> ms_q == '0 && $past(state_q) == pbseq_pkg::PBSEQ_OFF_DB)
		else $error("failsafe timer not started with alert");
	a_fs_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pbseq_pkg::PBSEQ_FAILSAFE && ms_q > fs_lim |-> 1'b0)
		else $error("failsafe overran");
	a_lockout_ignores: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pbseq_pkg::PBSEQ_LOCKOUT |=> !on_q)
		else $error("power on during lockout");
endmodule : pbseq_top
